// File: avf_pkg.sv
// Package for the access-violation interrupt and fault capture block.
// Assumes a 32-bit Avalon-MM register slave with word-aligned byte addresses.
// Functional notes
// - Reading the masked status register returns each raw violation bit ANDed with its enable.
// - Writing one to a masked status bit clears that pending violation; zero leaves it.
// - Writing one to an enable-set bit enables that violation interrupt; zero does nothing.
// - Reading the enable-set register returns the current enables.
// - Writing one to an enable-clear bit disables that violation interrupt; zero does nothing.
// - Reading the enable-clear register returns the same shared enables.
// - Reserved bits of status, enable, acknowledge and fault registers read as zero.
// - The acknowledge register is write-only with an 8-bit vector field in bits 7-0.
// - The full 32-bit address of the first faulting transfer is captured read-only.
// - Fault attributes hold transfer ID 31-24, master ID 23-16 and privilege ID 12-9.
// - Fault type 5-0 codes none, user exec/write/read 1/2/4, supervisor 8/10h/20h.
// - An addressing or protection violation raises the error interrupt.
// - The raw status register shows unmasked status; writing one sets a bit.
package avf_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_RAW = 8'h00;
   localparam logic [7:0] OFF_MSTAT = 8'h04;
   localparam logic [7:0] OFF_ENSET = 8'h08;
   localparam logic [7:0] OFF_ENCLR = 8'h0c;
   localparam logic [7:0] OFF_ACK = 8'h10;
   localparam logic [7:0] OFF_FADDR = 8'h14;
   localparam logic [7:0] OFF_FATTR = 8'h18;
   localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
   localparam int BIT_ADDR = 1;
   localparam int BIT_PROT = 0;
   localparam logic [5:0] FT_NONE = 6'h00;
   localparam logic [5:0] FT_UX = 6'h01;
   localparam logic [5:0] FT_UW = 6'h02;
   localparam logic [5:0] FT_UR = 6'h04;
   localparam logic [5:0] FT_SX = 6'h08;
   localparam logic [5:0] FT_SW = 6'h10;
   localparam logic [5:0] FT_SR = 6'h20;

   // One faulting transfer as seen by the address checker
   typedef struct packed {
      logic addr_err;
      logic prot_err;
      logic [31:0] addr;
      logic [7:0] xfer_id;
      logic [7:0] master_id;
      logic [3:0] priv_id;
      logic [5:0] ftype;
   } avf_fault_t;

   // Fault attribute register layout
   typedef struct packed {
      logic [7:0] xfer_id;
      logic [7:0] master_id;
      logic [2:0] rsvd_hi;
      logic [3:0] priv_id;
      logic [2:0] rsvd_lo;
      logic [5:0] ftype;
   } avf_attr_t;
endpackage : avf_pkg

// File: avf_tb.sv
// Self-checking bench for the violation interrupt and fault capture block.
// Assumes the single clock domain and two-cycle Avalon-MM answer of avf_top.
`timescale 1ns/100ps
module testbench;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_address = 8'h00;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic i_fault_valid = 1'b0;
   avf_pkg::avf_fault_t i_fault = '0;
   logic o_irq;
   logic o_irq_done_pulse;
   logic [7:0] o_irq_done_vector;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_pulse = 0;
   logic [31:0] d;
   logic [5:0] ft [7] = '{avf_pkg::FT_NONE, avf_pkg::FT_UX, avf_pkg::FT_UW, avf_pkg::FT_UR,
                          avf_pkg::FT_SX, avf_pkg::FT_SW, avf_pkg::FT_SR};
   avf_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(4'hf), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_fault_valid(i_fault_valid), .i_fault(i_fault), .o_irq(o_irq),
      .o_irq_done_pulse(o_irq_done_pulse), .o_irq_done_vector(o_irq_done_vector));
   always #5 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (o_irq_done_pulse === 1'b1) n_pulse <= n_pulse + 1;
      // Generous ceiling: the whole sequence needs well under 1000 cycles
      if (cyc == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask : chk
   // One Avalon cycle; starts a fresh edge so a release and a new request never collide
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge i_clock);
      i_address <= a;
      i_read <= !wr;
      i_write <= wr;
      i_writedata <= wd;
      do @(posedge i_clock); while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, a, wd, x);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, exp);
   endtask : rdchk
   task automatic flt(input logic ae, input logic pe, input logic [31:0] ad,
                      input logic [7:0] xi, input logic [7:0] mi, input logic [3:0] pi,
                      input logic [5:0] t);
      @(posedge i_clock);
      i_fault_valid <= 1'b1;
      i_fault <= '{addr_err: ae, prot_err: pe, addr: ad, xfer_id: xi, master_id: mi,
                   priv_id: pi, ftype: t};
      @(posedge i_clock);
      i_fault_valid <= 1'b0;
   endtask : flt
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge i_clock);
      i_rst_n <= 1'b1;
      for (int a = 0; a <= 8'h1c; a += 4) rdchk(8'(a), 32'h0);
      chk({31'h0, o_irq}, 32'h0);
      $display("test reset_values done");
      wr(avf_pkg::OFF_ENSET, 32'hffff_fffe);
      rdchk(avf_pkg::OFF_ENSET, 32'h2);
      rdchk(avf_pkg::OFF_ENCLR, 32'h2);
      wr(avf_pkg::OFF_ENSET, 32'h1);
      rdchk(avf_pkg::OFF_ENSET, 32'h3);
      wr(avf_pkg::OFF_ENCLR, 32'h2);
      wr(avf_pkg::OFF_ENCLR, 32'h0);
      rdchk(avf_pkg::OFF_ENCLR, 32'h1);
      $display("test enables done");
      wr(avf_pkg::OFF_ENSET, 32'h3);
      flt(1'b1, 1'b0, 32'h89ab_cdef, 8'h5a, 8'h3c, 4'ha, avf_pkg::FT_SW);
      rdchk(avf_pkg::OFF_RAW, 32'h2);
      chk({31'h0, o_irq}, 32'h1);
      rdchk(avf_pkg::OFF_FADDR, 32'h89ab_cdef);
      rdchk(avf_pkg::OFF_FATTR, {8'h5a, 8'h3c, 3'h0, 4'ha, 3'h0, avf_pkg::FT_SW});
      flt(1'b0, 1'b1, 32'h1111_2222, 8'h01, 8'h02, 4'h3, avf_pkg::FT_UR);
      rdchk(avf_pkg::OFF_FADDR, 32'h89ab_cdef);
      rdchk(avf_pkg::OFF_MSTAT, 32'h3);
      wr(avf_pkg::OFF_MSTAT, 32'h0);
      rdchk(avf_pkg::OFF_RAW, 32'h3);
      wr(avf_pkg::OFF_MSTAT, 32'h1);
      rdchk(avf_pkg::OFF_RAW, 32'h2);
      chk({31'h0, o_irq}, 32'h1);
      wr(avf_pkg::OFF_MSTAT, 32'h2);
      rdchk(avf_pkg::OFF_RAW, 32'h0);
      chk({31'h0, o_irq}, 32'h0);
      wr(avf_pkg::OFF_ENCLR, 32'h1);
      flt(1'b0, 1'b1, 32'h4444_0000, 8'h07, 8'h08, 4'h9, avf_pkg::FT_UX);
      rdchk(avf_pkg::OFF_RAW, 32'h1);
      rdchk(avf_pkg::OFF_MSTAT, 32'h0);
      chk({31'h0, o_irq}, 32'h0);
      rdchk(avf_pkg::OFF_FADDR, 32'h4444_0000);
      wr(avf_pkg::OFF_FADDR, 32'h0);
      rdchk(avf_pkg::OFF_FADDR, 32'h4444_0000);
      wr(avf_pkg::OFF_RAW, 32'h2);
      rdchk(avf_pkg::OFF_MSTAT, 32'h2);
      chk({31'h0, o_irq}, 32'h1);
      $display("test capture_and_status done");
      // Raw bits stay set here, so only the acknowledge releases each capture
      wr(avf_pkg::OFF_ACK, 32'h0);
      for (int i = 0; i < 7; i++) begin
         flt(1'b1, 1'b0, {24'h0, 8'(i)}, 8'(i), 8'h80, 4'(i), ft[i]);
         rdchk(avf_pkg::OFF_FADDR, {24'h0, 8'(i)});
         rdchk(avf_pkg::OFF_FATTR, {8'(i), 8'h80, 3'h0, 4'(i), 3'h0, ft[i]});
         wr(avf_pkg::OFF_ACK, {24'h0, 8'ha0 + 8'(i)});
      end
      rdchk(avf_pkg::OFF_ACK, 32'h0);
      chk(32'(n_pulse), 32'h8);
      chk({24'h0, o_irq_done_vector}, 32'ha6);
      $display("test acknowledge_and_types done");
      tally_and_finish();
   end
endmodule : testbench

// File: avf_top.sv
// Access-violation interrupt status, enables, acknowledge and first-fault capture.
// Assumes fault reports arrive as one-cycle strobes synchronous to i_clock.
`timescale 1ns/100ps
module avf_top (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Avalon-MM slave
   input wire logic [avf_pkg::ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Fault report from the register space checker
   input wire logic i_fault_valid,
   input wire avf_pkg::avf_fault_t i_fault,
   // Interrupt and acknowledge
   output logic o_irq,
   output logic o_irq_done_pulse,
   output logic [7:0] o_irq_done_vector
);

   ////////////////////////////////////////////////////////////////////////////////
   logic [1:0] raw_r;
   logic [1:0] en_r;
   logic [31:0] fault_addr_r;
   avf_pkg::avf_attr_t attr_r;
   logic held_r;
   logic ack_r;
   logic [31:0] rdata_nxt;
   logic wr_go;
   logic rd_go;
   logic [1:0] ev;
   logic [1:0] w1c;
   logic [1:0] w1s;
   logic ack_wr;

   // Every access takes two cycles: waitrequest high in the first, low in the second.
   // The extra cycle keeps read data registered at the cost of bus throughput.
   // Waitrequest is registered as well, so it mirrors the inverse of ack_r exactly
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
         o_waitrequest <= 1'b1;
      end else begin
         ack_r <= (i_read || i_write) && !ack_r;
         o_waitrequest <= !((i_read || i_write) && !ack_r);
      end
   end

   assign wr_go = i_write && ack_r;
   assign rd_go = i_read && !ack_r;

   assign ev = {i_fault_valid && i_fault.addr_err, i_fault_valid && i_fault.prot_err};
   assign w1c = (wr_go && i_byteenable[0] && i_address == avf_pkg::OFF_MSTAT)
                ? i_writedata[1:0] : 2'h0;
   assign w1s = (wr_go && i_byteenable[0] && i_address == avf_pkg::OFF_RAW)
                ? i_writedata[1:0] : 2'h0;
   assign ack_wr = wr_go && i_address == avf_pkg::OFF_ACK;

   ////////////////////////////////////////////////////////////////////////////////
   // Raw status: hardware events and software set win over a same-cycle clear
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         raw_r <= 2'h0;
      end else begin
         raw_r <= (raw_r & ~w1c) | ev | w1s;
      end
   end

   // Shared enable state behind the set and clear registers
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_r <= 2'h0;
      end else if (wr_go && i_byteenable[0]) begin
         if (i_address == avf_pkg::OFF_ENSET) begin
            en_r <= en_r | i_writedata[1:0];
         end else if (i_address == avf_pkg::OFF_ENCLR) begin
            en_r <= en_r & ~i_writedata[1:0];
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(raw_r & en_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Acknowledge: write-only; the vector is exported for the interrupt distributor
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq_done_pulse <= 1'b0;
         o_irq_done_vector <= 8'h00;
      end else begin
         o_irq_done_pulse <= ack_wr;
         if (ack_wr && i_byteenable[0]) begin
            o_irq_done_vector <= i_writedata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // First-fault capture; a held record is released by clearing all pending
   // status or by an acknowledge write, and a new fault in an acknowledge cycle is kept.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         held_r <= 1'b0;
         fault_addr_r <= 32'h0000_0000;
         attr_r <= '0;
      end else begin
         if (i_fault_valid && (i_fault.addr_err || i_fault.prot_err)
             && (!held_r || ack_wr)) begin
            held_r <= 1'b1;
            fault_addr_r <= i_fault.addr;
            attr_r.xfer_id <= i_fault.xfer_id;
            attr_r.master_id <= i_fault.master_id;
            attr_r.priv_id <= i_fault.priv_id;
            attr_r.ftype <= i_fault.ftype;
         end else if (ack_wr || (held_r && (((raw_r & ~w1c) | ev | w1s) == 2'h0))) begin
            held_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      rdata_nxt = avf_pkg::UNMAPPED_VAL;
      unique case (i_address)
         avf_pkg::OFF_RAW: rdata_nxt = {30'h0, raw_r};
         avf_pkg::OFF_MSTAT: rdata_nxt = {30'h0, raw_r & en_r};
         avf_pkg::OFF_ENSET: rdata_nxt = {30'h0, en_r};
         avf_pkg::OFF_ENCLR: rdata_nxt = {30'h0, en_r};
         avf_pkg::OFF_ACK: rdata_nxt = 32'h0000_0000;
         avf_pkg::OFF_FADDR: rdata_nxt = fault_addr_r;
         avf_pkg::OFF_FATTR: rdata_nxt = {attr_r.xfer_id, attr_r.master_id, 3'h0,
                                          attr_r.priv_id, 3'h0, attr_r.ftype};
         default: rdata_nxt = avf_pkg::UNMAPPED_VAL;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_readdata <= 32'h0000_0000;
      end else if (rd_go) begin
         o_readdata <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   masked_irq_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      1'b1 |=> o_irq == |($past(raw_r) & $past(en_r)))
      else $error("irq does not follow masked status");

   w1c_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (w1c[0] && !ev[0] && !w1s[0]) |=> !raw_r[0])
      else $error("protection status not cleared");

   event_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ev[1] |=> raw_r[1])
      else $error("addressing event lost");

   raw_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      w1s[0] |=> raw_r[0])
      else $error("raw set ignored");

   enable_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (wr_go && i_byteenable[0] && i_address == avf_pkg::OFF_ENSET && i_writedata[1])
      |=> en_r[1])
      else $error("enable set failed");

   enable_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (wr_go && i_byteenable[0] && i_address == avf_pkg::OFF_ENCLR && i_writedata[0])
      |=> !en_r[0])
      else $error("enable clear failed");

   mstat_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (rd_go && i_address == avf_pkg::OFF_MSTAT)
      |=> o_readdata == {30'h0, $past(raw_r) & $past(en_r)})
      else $error("masked status read wrong");

   fault_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (held_r && !ack_wr) |=> fault_addr_r == $past(fault_addr_r))
      else $error("held fault overwritten");

   fault_capture_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_fault_valid && i_fault.addr_err && !held_r)
      |=> fault_addr_r == $past(i_fault.addr) && held_r)
      else $error("fault address not captured");

   wait_cycle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ((i_read || i_write) && o_waitrequest) |=> !o_waitrequest)
      else $error("slave answer late");
endmodule : avf_top
